// ==== rtl/jtp_map.svh ====
// constants for the test access port: state-independent figures only
// assumes inclusion by the port module and its bench
`ifndef JTP_MAP_SVH
`define JTP_MAP_SVH
`define JTP_IR_W        4
`define JTP_IR_RESET    4'h1
`define JTP_IR_CAPTURE  4'h1
`define JTP_IR_BYPASS   4'hF
`define JTP_SYNC_STAGES 2
`define JTP_TLR_EDGES   3'h5
`endif

// ==== rtl/jtp_pkg.sv ====
// types for the test access port
// assumes nothing of its surroundings
package jtp_pkg;
  typedef enum logic [3:0] {
    JTP_TLR, JTP_RTI, JTP_SEL_DR, JTP_CAP_DR, JTP_SHF_DR, JTP_EX1_DR, JTP_PAU_DR,
    JTP_EX2_DR, JTP_UPD_DR, JTP_SEL_IR, JTP_CAP_IR, JTP_SHF_IR, JTP_EX1_IR,
    JTP_PAU_IR, JTP_EX2_IR, JTP_UPD_IR
  } jtp_state_t;
endpackage

// ==== rtl/jtp_tap_port.sv ====
// test access port: pins sampled on the core clock, edges of the test clock found
// assumes test pins are asynchronous and the test clock is far slower than the core clock
//
// What the port and its host must do
// RQ1: test clock comes from the host and times all test logic and shifting.
// RQ2: data input captured on each rising test clock edge; undriven reads high.
// RQ3: mode select sampled each rising edge steps the state machine; undriven high.
// RQ4: data output driven only in shift states, otherwise high impedance.
// RQ5: data output changes only on falling test clock edges.
// RQ6: low test reset resets the state machine without any test clock.
// RQ7: host should assert test reset whenever it asserts chip reset; test_core_reset in the bench asserts chip reset alone.
// RQ8: chip reset alone leaves the test port and debug state untouched.
// RQ9: standard sixteen-state sequence; five high mode edges reach logic reset.
`timescale 1ns/1ps
`include "jtp_map.svh"
module jtp_tap_port (
  // core clock and chip reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_n_in,
  // test pins
  input  wire logic                   tck_in,
  input  wire logic                   tms_in,
  input  wire logic                   tdi_in,
  input  wire logic                   trst_n_in,
  output logic                        tdo_out,
  output logic                        tdo_oe_out,
  // debug side
  output logic [`JTP_IR_W-1:0]        instr_out,
  output logic                        in_reset_out,
  output logic                        core_reset_out
);
  logic [1:0] tck_s_ff, tms_s_ff, tdi_s_ff, trst_s_ff;
  logic       tck_d_ff;
  logic       rise, fall, trst_n_q;
  logic [2:0] hi_cnt_ff;
  jtp_pkg::jtp_state_t state_ff, nxt_state;
  logic [`JTP_IR_W-1:0] ir_sh_ff, ir_ff;
  logic       byp_ff, tdo_ff, oe_ff;

  // RQ1 sync pins; second stage only feeds logic
  always_ff @(posedge core_clk_in) begin
    tck_s_ff  <= {tck_s_ff[0], tck_in};
    tms_s_ff  <= {tms_s_ff[0], tms_in};
    tdi_s_ff  <= {tdi_s_ff[0], tdi_in};
    trst_s_ff <= {trst_s_ff[0], trst_n_in};
    tck_d_ff  <= tck_s_ff[1];
  end
  assign rise     = tck_s_ff[1] & ~tck_d_ff;
  assign fall     = ~tck_s_ff[1] & tck_d_ff;
  assign trst_n_q = trst_s_ff[1];

  // RQ9 high mode edge count
  // checker aid only; saturates so long idle in logic reset stays legal
  always_ff @(posedge core_clk_in) begin
    if (!trst_n_q)
      hi_cnt_ff <= 3'h0;
    else if (rise && !tms_s_ff[1])
      hi_cnt_ff <= 3'h0;
    else if (rise && hi_cnt_ff != `JTP_TLR_EDGES)
      hi_cnt_ff <= hi_cnt_ff + 3'h1;
  end

  // RQ9 next state on mode select
  always_comb begin
    case (state_ff)
      jtp_pkg::JTP_TLR:    nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_TLR    : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_RTI:    nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_SEL_DR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_SEL_IR : jtp_pkg::JTP_CAP_DR;
      jtp_pkg::JTP_CAP_DR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_EX1_DR : jtp_pkg::JTP_SHF_DR;
      jtp_pkg::JTP_SHF_DR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_EX1_DR : jtp_pkg::JTP_SHF_DR;
      jtp_pkg::JTP_EX1_DR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_UPD_DR : jtp_pkg::JTP_PAU_DR;
      jtp_pkg::JTP_PAU_DR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_EX2_DR : jtp_pkg::JTP_PAU_DR;
      jtp_pkg::JTP_EX2_DR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_UPD_DR : jtp_pkg::JTP_SHF_DR;
      jtp_pkg::JTP_UPD_DR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
      jtp_pkg::JTP_SEL_IR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_TLR    : jtp_pkg::JTP_CAP_IR;
      jtp_pkg::JTP_CAP_IR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_EX1_IR : jtp_pkg::JTP_SHF_IR;
      jtp_pkg::JTP_SHF_IR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_EX1_IR : jtp_pkg::JTP_SHF_IR;
      jtp_pkg::JTP_EX1_IR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_UPD_IR : jtp_pkg::JTP_PAU_IR;
      jtp_pkg::JTP_PAU_IR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_EX2_IR : jtp_pkg::JTP_PAU_IR;
      jtp_pkg::JTP_EX2_IR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_UPD_IR : jtp_pkg::JTP_SHF_IR;
      jtp_pkg::JTP_UPD_IR: nxt_state = tms_s_ff[1] ? jtp_pkg::JTP_SEL_DR : jtp_pkg::JTP_RTI;
      default:             nxt_state = jtp_pkg::JTP_TLR;
    endcase
  end

  // RQ6 test reset only; RQ8 chip reset deliberately not used here
  always_ff @(posedge core_clk_in) begin
    if (!trst_n_q)
      state_ff <= jtp_pkg::JTP_TLR;
    else if (rise)
      state_ff <= nxt_state;
  end

  // RQ2 shift data input on rising edge
  always_ff @(posedge core_clk_in) begin
    if (!trst_n_q || state_ff == jtp_pkg::JTP_TLR) begin
      ir_sh_ff <= `JTP_IR_RESET;
      ir_ff    <= `JTP_IR_RESET;
      byp_ff   <= 1'b0;
    end else if (rise) begin
      case (state_ff)
        jtp_pkg::JTP_CAP_IR: ir_sh_ff <= `JTP_IR_CAPTURE;
        jtp_pkg::JTP_SHF_IR: ir_sh_ff <= {tdi_s_ff[1], ir_sh_ff[`JTP_IR_W-1:1]};
        jtp_pkg::JTP_UPD_IR: ir_ff    <= ir_sh_ff;
        jtp_pkg::JTP_CAP_DR: byp_ff   <= 1'b0;
        jtp_pkg::JTP_SHF_DR: byp_ff   <= tdi_s_ff[1];
        default: ;
      endcase
    end
  end

  // RQ4 RQ5 output and enable move on falling edge or clear on test reset
  always_ff @(posedge core_clk_in) begin
    if (!trst_n_q) begin
      tdo_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else if (fall) begin
      oe_ff  <= (state_ff == jtp_pkg::JTP_SHF_IR) || (state_ff == jtp_pkg::JTP_SHF_DR);
      tdo_ff <= (state_ff == jtp_pkg::JTP_SHF_IR) ? ir_sh_ff[0] : byp_ff;
    end
  end

  assign tdo_out        = tdo_ff;
  assign tdo_oe_out     = oe_ff;
  assign instr_out      = ir_ff;
  assign in_reset_out   = (state_ff == jtp_pkg::JTP_TLR);
  // RQ8 core reset follows chip reset alone
  assign core_reset_out = ~rst_n_in;

  // RQ6 test reset forces logic reset
  property p_trst;
    @(posedge core_clk_in) !trst_n_q |=> state_ff == jtp_pkg::JTP_TLR;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored"); // RQ6

  // RQ4 enable only in shift states
  property p_oe;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      fall |=> tdo_oe_out == ($past(state_ff) == jtp_pkg::JTP_SHF_IR
                             || $past(state_ff) == jtp_pkg::JTP_SHF_DR);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong"); // RQ4

  // RQ5 output stable without falling edge
  property p_tdo_fall;
    @(posedge core_clk_in) disable iff (!trst_n_q) !fall |=> $stable(tdo_out);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("output moved off edge"); // RQ5

  // RQ3 state holds between rising edges
  property p_step;
    @(posedge core_clk_in) disable iff (!trst_n_q) !rise |=> $stable(state_ff);
  endproperty
  a_step: assert property (p_step) else $error("state moved off edge"); // RQ3

  // RQ9 high mode edge steps
  sequence s_rise_high;
    rise && tms_s_ff[1];
  endsequence
  sequence s_fifth_high;
    (hi_cnt_ff >= `JTP_TLR_EDGES - 3'h1) ##0 s_rise_high;
  endsequence
  property p_tlr_hold;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      (state_ff == jtp_pkg::JTP_TLR) ##0 s_rise_high |=> state_ff == jtp_pkg::JTP_TLR;
  endproperty
  a_tlr_hold: assert property (p_tlr_hold) else $error("left logic reset"); // RQ9

  // RQ9 five high edges reach logic reset
  property p_five_high;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      s_fifth_high |=> state_ff == jtp_pkg::JTP_TLR;
  endproperty
  a_five_high: assert property (p_five_high) else $error("five high edges missed"); // RQ9

  // RQ2 bypass takes data input
  property p_byp;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      (rise && state_ff == jtp_pkg::JTP_SHF_DR) |=> byp_ff == $past(tdi_s_ff[1]);
  endproperty
  a_byp: assert property (p_byp) else $error("data input not shifted"); // RQ2

  // RQ8 chip reset leaves port alone
  property p_chip;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      (!rst_n_in && !rise && state_ff != jtp_pkg::JTP_TLR) |=> $stable(state_ff) && $stable(ir_ff);
  endproperty
  a_chip: assert property (p_chip) else $error("chip reset hit port"); // RQ8

  // RQ1 enable only changes at falling edge
  property p_oe_edge;
    @(posedge core_clk_in) disable iff (!trst_n_q) !fall |=> $stable(tdo_oe_out);
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("enable moved off edge"); // RQ1

  // RQ5 output bit at falling edge
  property p_tdo_val;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      fall |=> tdo_out == (($past(state_ff) == jtp_pkg::JTP_SHF_IR) ? $past(ir_sh_ff[0])
                                                                   : $past(byp_ff));
  endproperty
  a_tdo_val: assert property (p_tdo_val) else $error("output bit wrong"); // RQ5

  // RQ2 instruction shift takes input
  property p_shift_ir;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      (rise && state_ff == jtp_pkg::JTP_SHF_IR)
        |=> ir_sh_ff == {$past(tdi_s_ff[1]), $past(ir_sh_ff[`JTP_IR_W-1:1])};
  endproperty
  a_shift_ir: assert property (p_shift_ir) else $error("instruction shift wrong"); // RQ2

  // RQ9 capture loads fixed pattern
  property p_cap_ir;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      (rise && state_ff == jtp_pkg::JTP_CAP_IR) |=> ir_sh_ff == `JTP_IR_CAPTURE;
  endproperty
  a_cap_ir: assert property (p_cap_ir) else $error("capture pattern wrong"); // RQ9

  // RQ9 update latches instruction
  property p_ir_upd;
    @(posedge core_clk_in) disable iff (!trst_n_q)
      (rise && state_ff == jtp_pkg::JTP_UPD_IR) |=> ir_ff == $past(ir_sh_ff);
  endproperty
  a_ir_upd: assert property (p_ir_upd) else $error("instruction not updated"); // RQ9

  // RQ4 test reset drops enable
  property p_oe_trst;
    @(posedge core_clk_in) !trst_n_q |=> !tdo_oe_out;
  endproperty
  a_oe_trst: assert property (p_oe_trst) else $error("enable kept in test reset"); // RQ4
endmodule // jtp_tap_port

// ==== tb/jtp_host.sv ====
// debug probe model: drives the test pins, samples serial out
// assumes the core clock paces it; test clock idles low between frames
`timescale 1ns/1ps
module jtp_host (
  // pacing and device answer
  input  wire logic core_clk_in,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in,
  // test pins
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  output logic      trst_n_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trst_n_out = 1'b0;
  end
  task automatic set_trst(input logic v);
    @(negedge core_clk_in);
    trst_n_out = v;
  endtask
  task automatic bit_cyc(input logic m, input logic d, output logic q, output logic oe);
    @(negedge core_clk_in);
    tms_out = m;
    tdi_out = d;
    repeat (4) @(negedge core_clk_in);
    // released pin has no pull; shown inverted so a stray sample shows up
    q = tdo_oe_in ? tdo_in : ~tdo_in;
    oe = tdo_oe_in;
    tck_out = 1'b1;
    repeat (3) @(negedge core_clk_in);
    tck_out = 1'b0;
  endtask
endmodule // jtp_host

// ==== tb/test_jtp_tap_port.sv ====
// bench for the test access port, probe model on the pins
// assumes a 50 MHz core clock and a 160 ns test clock
`timescale 1ns/1ps
`include "jtp_map.svh"
module test_jtp_tap_port;
  logic       core_clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       tck, tms, tdi, trst_n, tdo, oe, in_rst, core_rst, q, e;
  logic [3:0] instr, got, oes;
  int         bad_count = 0;
  int         num_checks = 0;
  int         cyc = 0;
  always #10 core_clk_in = ~core_clk_in;
  jtp_host host (.core_clk_in(core_clk_in), .tdo_in(tdo), .tdo_oe_in(oe), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n));
  jtp_tap_port DUT (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(oe),
    .instr_out(instr), .in_reset_out(in_rst), .core_reset_out(core_rst));
  task automatic chk(string n, logic [3:0] x, logic [3:0] g);
    num_checks++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      bad_count++;
    end
  endtask
  task automatic walk(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) host.bit_cyc(m[i], 1'b1, q, e);
  endtask
  task automatic shift(input logic [3:0] d);
    for (int i = 0; i < 4; i++) begin
      host.bit_cyc(i == 3, d[i], got[i], oes[i]);
    end
    walk(8'h01, 2);
    repeat (6) @(negedge core_clk_in);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, whole run needs well under this
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic test_reset;
    repeat (6) @(negedge core_clk_in);
    chk("in_reset", 4'h1, {3'h0, in_rst});
    chk("core_reset", 4'h1, {3'h0, core_rst});
    rst_n_in = 1'b1;
    host.set_trst(1'b1);
    chk("core_release", 4'h0, {3'h0, core_rst});
    walk(8'h1F, 5);
    chk("tlr", 4'h1, {3'h0, in_rst});
    chk("instr_reset", `JTP_IR_RESET, instr);
    $display("test reset done");
  endtask
  task automatic test_ir;
    walk(8'h06, 5);
    shift(4'hA);
    chk("ir_out", `JTP_IR_CAPTURE, got);
    chk("oe_ir", 4'hF, oes);
    chk("instr", 4'hA, instr);
    chk("oe_idle", 4'h0, {3'h0, oe});
    $display("test ir done");
  endtask
  task automatic test_dr;
    walk(8'h01, 3);
    shift(4'h5);
    chk("bypass", 4'hA, got);
    chk("oe_dr", 4'hF, oes);
    $display("test dr done");
  endtask
  task automatic test_core_reset;
    rst_n_in = 1'b0;
    repeat (6) @(negedge core_clk_in);
    chk("core_reset_on", 4'h1, {3'h0, core_rst});
    chk("keep_instr", 4'hA, instr);
    chk("keep_state", 4'h0, {3'h0, in_rst});
    rst_n_in = 1'b1;
    @(negedge core_clk_in);
    chk("core_reset_off", 4'h0, {3'h0, core_rst});
    $display("test core reset done");
  endtask
  task automatic test_trst;
    walk(8'h01, 3);
    repeat (4) @(negedge core_clk_in);
    chk("shift_oe", 4'h1, {3'h0, oe});
    host.set_trst(1'b0);
    rst_n_in = 1'b0;
    repeat (6) @(negedge core_clk_in);
    chk("trst_state", 4'h1, {3'h0, in_rst});
    chk("trst_instr", `JTP_IR_RESET, instr);
    chk("trst_oe", 4'h0, {3'h0, oe});
    host.set_trst(1'b1);
    rst_n_in = 1'b1;
    repeat (6) @(negedge core_clk_in);
    chk("trst_release", 4'h1, {3'h0, in_rst});
    $display("test test reset done");
  endtask
  task automatic test_five_high;
    walk(8'h06, 5);
    shift(4'h5);
    chk("instr_five", 4'h5, instr);
    walk(8'h01, 3);
    repeat (4) @(negedge core_clk_in);
    chk("oe_five", 4'h1, {3'h0, oe});
    walk(8'h1F, 5);
    repeat (4) @(negedge core_clk_in);
    chk("five_tlr", 4'h1, {3'h0, in_rst});
    chk("five_instr", `JTP_IR_RESET, instr);
    chk("five_oe", 4'h0, {3'h0, oe});
    $display("test five high done");
  endtask
  initial begin
    test_reset();
    test_ir();
    test_dr();
    test_core_reset();
    test_trst();
    test_five_high();
    summarize();
  end
endmodule // test_jtp_tap_port
